// >>> rtc_cal_pkg.sv
// Constants, types and state record of the calendar real-time counter
package rtc_cal_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL        = 8'h00;
  localparam logic [7:0] OFF_IRQ_CONTROL = 8'h04;
  localparam logic [7:0] OFF_STATUS      = 8'h08;
  localparam logic [7:0] OFF_COMP_CONFIG = 8'h0c;
  localparam logic [7:0] OFF_TICK_COUNT  = 8'h10;
  localparam logic [7:0] OFF_TICK_LIMIT  = 8'h14;
  localparam logic [7:0] OFF_SECONDS     = 8'h18;
  localparam logic [7:0] OFF_MINUTES     = 8'h1c;
  localparam logic [7:0] OFF_HOURS       = 8'h20;
  localparam logic [7:0] OFF_UNLOCK      = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_SRC_BIT     = 1;
  localparam int CTRL_PRESC_LSB   = 8;
  localparam int FLAG_QSEC_BIT    = 0;
  localparam int FLAG_COMP_BIT    = 2;
  localparam int FLAG_SEC_BIT     = 3;
  localparam int FLAG_MIN_BIT     = 4;
  localparam int FLAG_HR_BIT      = 5;
  localparam int STATUS_BUSY_BIT  = 7;
  localparam int COMP_CCS_LSB     = 6;
  localparam int UNLOCK_STATE_LSB = 2;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [5:0]  SEC_MAX     = 6'h3b;
  localparam logic [5:0]  MIN_MAX     = 6'h3b;
  localparam logic [4:0]  HR_MAX      = 5'h17;
  localparam logic [4:0]  DIV32_LAST  = 5'h1f;
  localparam logic [5:0]  CYCLE_LEN_0 = 6'h05;
  localparam logic [5:0]  CYCLE_LEN_1 = 6'h0f;
  localparam logic [5:0]  CYCLE_LEN_2 = 6'h1e;
  localparam logic [5:0]  CYCLE_LEN_3 = 6'h3c;
  localparam logic [1:0]  UNLOCK_FIRST  = 2'h2;
  localparam logic [1:0]  UNLOCK_SECOND = 2'h1;
  localparam logic [1:0]  UNLOCK_LOCK   = 2'h0;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {WP_OPEN, WP_LOCKED, WP_ARMED} wp_state_t;

  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic [2:0]  main_sync;
    logic [2:0]  lf_sync;
    logic        enable;
    logic        src_sel;
    logic [7:0]  prescaler;
    logic        lf_osc_on;
    logic [7:0]  pre_cnt;
    logic [4:0]  div32;
    logic [5:0]  irq_en;
    logic [5:0]  flags;
    logic        busy;
    logic [1:0]  ccs;
    logic [5:0]  q;
    logic [15:0] limit;
    logic [1:0]  w_ccs;
    logic [5:0]  w_q;
    logic [15:0] w_limit;
    logic [15:0] cnt;
    logic [5:0]  pos;
    logic [15:0] qcnt;
    logic [1:0]  qidx;
    logic [5:0]  sec;
    logic [5:0]  min;
    logic [4:0]  hr;
    wp_state_t   wp;
  } rtc_state_t;

endpackage : rtc_cal_pkg

// >>> rtc_calendar_compensation.sv
// Calendar real-time counter with frequency compensation, AHB-Lite slave
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - 16-bit counter with writable compare limit
// - Counter returns to zero at limit
// - Time registers readable, writes load counters
// - Seconds write above 59 ignored
// - Minutes write above 59 ignored
// - Hours write above 23 ignored
// - Seconds and minutes wrap after 59
// - Hours wrap after 23
// - Time registers writable only when unlocked
// - Flags on each time increment, enabled interrupt
// - Main oscillator default, 32 kHz selectable
// - Prescaled 1 MHz divided by 32
// - 32 kHz oscillator stays on once enabled
// - Cycle select gives 5/15/30/60 seconds
// - Compensation flag at last cycle second
// - Quarter-second flag on 4 Hz tick
// - Limit+1 for first long seconds
// - Long count beyond cycle means all long
// - Counter wrap is the one-second tick
// - Working copies loaded at cycle end, busy
// - Unprotected after reset, two-bit unlock sequence
// - Write one clears a flag
module rtc_calendar_compensation (
  input  wire logic        hclk,               // Bus and logic clock
  input  wire logic        hresetn,            // Async reset, active low
  input  wire logic        hsel,               // Slave select
  input  wire logic [31:0] haddr,              // Byte address
  input  wire logic [1:0]  htrans,             // Transfer type
  input  wire logic        hwrite,             // Write when high
  input  wire logic [2:0]  hsize,              // Transfer size
  input  wire logic [31:0] hwdata,             // Write data
  input  wire logic        hready,             // Bus ready in
  output logic [31:0]      hrdata,             // Read data
  output logic             hreadyout,          // Slave ready
  output logic             hresp,              // Response, always OKAY
  input  wire logic        main_osc_clock,     // Main oscillator pin
  input  wire logic        low_freq_osc_clock, // 32 kHz oscillator pin
  output logic             low_osc_enable,     // Keeps 32 kHz osc running
  output logic             irq_request         // Combined interrupt
);

  rtc_cal_pkg::rtc_state_t s_q;
  rtc_cal_pkg::rtc_state_t s_d;

  logic        main_rise;
  logic        lf_rise;
  logic        pre_tick;
  logic        main_tick;
  logic        src_tick;
  logic        long_sec;
  logic [16:0] period;
  logic [15:0] quarter;
  logic [16:0] qnext;
  logic        sec_tick;
  logic        qtick;
  logic [5:0]  cycle_len;
  logic [5:0]  pos_next;
  logic        comp_end;
  logic        last_sec;
  logic        sec_wrap;
  logic        min_wrap;
  logic        wr;
  logic [7:0]  wa;
  logic        unlocked;
  logic [5:0]  flag_set;
  logic [5:0]  flag_clr;
  logic        rd_sel;
  logic [31:0] rd_data;

  // ----------------------------------------------------------------
  // Cycle length lookup
  // ----------------------------------------------------------------
  function automatic logic [5:0] len_of(input logic [1:0] sel);
    logic [5:0] l;
    l = rtc_cal_pkg::CYCLE_LEN_0;
    unique case (sel)
      2'h0: l = rtc_cal_pkg::CYCLE_LEN_0;
      2'h1: l = rtc_cal_pkg::CYCLE_LEN_1;
      2'h2: l = rtc_cal_pkg::CYCLE_LEN_2;
      2'h3: l = rtc_cal_pkg::CYCLE_LEN_3;
    endcase
    return l;
  endfunction : len_of

  always_comb begin
    s_d = s_q;

    // --------------------------------------------------------------
    // Oscillator pins and clock derivation
    // --------------------------------------------------------------
    // Pins are asynchronous, so each passes two flops before use
    s_d.main_sync = {s_q.main_sync[1:0], main_osc_clock};
    s_d.lf_sync   = {s_q.lf_sync[1:0], low_freq_osc_clock};
    main_rise = s_q.main_sync[1] & ~s_q.main_sync[2];
    lf_rise   = s_q.lf_sync[1] & ~s_q.lf_sync[2];

    pre_tick = 1'b0;
    if (main_rise) begin
      if (s_q.pre_cnt >= s_q.prescaler) begin
        s_d.pre_cnt = 8'h00;
        pre_tick    = 1'b1;
      end else begin
        s_d.pre_cnt = s_q.pre_cnt + 8'h01;
      end
    end
    main_tick = pre_tick && (s_q.div32 == rtc_cal_pkg::DIV32_LAST);
    s_d.div32 = s_q.div32 + {4'h0, pre_tick};

    src_tick = s_q.enable & (s_q.src_sel ? lf_rise : main_tick);

    // --------------------------------------------------------------
    // Compensated tick counter
    // --------------------------------------------------------------
    // long seconds first
    long_sec = ({2'b00, s_q.pos} < {2'b00, s_q.w_q});
    period   = {1'b0, s_q.w_limit} + {16'h0000, long_sec};
    sec_tick = src_tick &&
               (({1'b0, s_q.cnt} == period) || (s_q.cnt == 16'hffff));
    if (sec_tick) begin
      s_d.cnt = rtc_cal_pkg::COUNT_RESET;
    end else if (src_tick) begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end

    quarter = 16'((period + 17'h00001) >> 2);
    qnext   = {1'b0, s_q.qcnt} + 17'h00001;
    qtick   = 1'b0;
    if (sec_tick) begin
      s_d.qcnt = 16'h0000;
      s_d.qidx = 2'h0;
      qtick    = 1'b1;
    end else if (src_tick) begin
      if ((qnext == {1'b0, quarter}) && (s_q.qidx != 2'h3)) begin
        s_d.qcnt = 16'h0000;
        s_d.qidx = s_q.qidx + 2'h1;
        qtick    = 1'b1;
      end else begin
        s_d.qcnt = 16'(qnext);
      end
    end

    // --------------------------------------------------------------
    // Compensation cycle
    // --------------------------------------------------------------
    // cycle length
    cycle_len = len_of(s_q.w_ccs);
    comp_end  = sec_tick && (s_q.pos == (cycle_len - 6'h01));
    pos_next  = comp_end ? 6'h00 : s_q.pos + 6'h01;
    last_sec  = sec_tick && !comp_end &&
                (pos_next == (cycle_len - 6'h01));
    if (!s_q.enable) begin
      // Idle counter follows the settings so the first cycle uses them
      s_d.pos     = 6'h00;
      s_d.w_limit = s_q.limit;
      s_d.w_q     = s_q.q;
      s_d.w_ccs   = s_q.ccs;
      s_d.busy    = 1'b0;
    end else begin
      if (sec_tick) begin
        s_d.pos = pos_next;
      end
      if (s_q.busy) begin
        s_d.w_limit = s_q.limit;
        s_d.w_q     = s_q.q;
        s_d.w_ccs   = s_q.ccs;
        s_d.busy    = 1'b0;
      end else if (comp_end) begin
        s_d.busy = 1'b1;
      end
    end

    // --------------------------------------------------------------
    // Calendar counters
    // --------------------------------------------------------------
    // seconds and minutes wrap
    sec_wrap = sec_tick && (s_q.sec == rtc_cal_pkg::SEC_MAX);
    min_wrap = sec_wrap && (s_q.min == rtc_cal_pkg::MIN_MAX);
    if (sec_tick) begin
      s_d.sec = sec_wrap ? 6'h00 : s_q.sec + 6'h01;
    end
    if (sec_wrap) begin
      s_d.min = min_wrap ? 6'h00 : s_q.min + 6'h01;
    end
    if (min_wrap) begin
      s_d.hr = (s_q.hr == rtc_cal_pkg::HR_MAX) ? 5'h00 : s_q.hr + 5'h01;
    end

    // --------------------------------------------------------------
    // Register writes in the data phase
    // --------------------------------------------------------------
    wr       = s_q.wr_pend;
    wa       = s_q.wr_addr;
    unlocked = (s_q.wp == rtc_cal_pkg::WP_OPEN);
    flag_clr = 6'h00;
    if (wr) begin
      unique case (wa)
        rtc_cal_pkg::OFF_CTRL: begin
          // Control is protected together with the time registers
          if (unlocked) begin
            s_d.enable    = hwdata[rtc_cal_pkg::CTRL_ENABLE_BIT];
            s_d.src_sel   = hwdata[rtc_cal_pkg::CTRL_SRC_BIT];
            s_d.prescaler = hwdata[rtc_cal_pkg::CTRL_PRESC_LSB +: 8];
          end
        end
        rtc_cal_pkg::OFF_IRQ_CONTROL: s_d.irq_en = hwdata[5:0];
        rtc_cal_pkg::OFF_STATUS: begin
          flag_clr = hwdata[5:0];
        end
        rtc_cal_pkg::OFF_COMP_CONFIG: begin
          if (!s_q.busy) begin
            s_d.ccs = hwdata[rtc_cal_pkg::COMP_CCS_LSB +: 2];
            s_d.q   = hwdata[5:0];
          end
        end
        rtc_cal_pkg::OFF_TICK_LIMIT: begin
          if (!s_q.busy) begin
            s_d.limit = hwdata[15:0];
          end
        end
        rtc_cal_pkg::OFF_SECONDS: begin
          if (unlocked &&
              (hwdata[7:0] <= {2'b00, rtc_cal_pkg::SEC_MAX})) begin
            s_d.sec = hwdata[5:0];
          end
        end
        rtc_cal_pkg::OFF_MINUTES: begin
          if (unlocked &&
              (hwdata[7:0] <= {2'b00, rtc_cal_pkg::MIN_MAX})) begin
            s_d.min = hwdata[5:0];
          end
        end
        rtc_cal_pkg::OFF_HOURS: begin
          if (unlocked &&
              (hwdata[7:0] <= {3'b000, rtc_cal_pkg::HR_MAX})) begin
            s_d.hr = hwdata[4:0];
          end
        end
        rtc_cal_pkg::OFF_UNLOCK: begin
          if (hwdata[1:0] == rtc_cal_pkg::UNLOCK_LOCK) begin
            s_d.wp = rtc_cal_pkg::WP_LOCKED;
          end else begin
            unique case (s_q.wp)
              rtc_cal_pkg::WP_OPEN: s_d.wp = rtc_cal_pkg::WP_OPEN;
              rtc_cal_pkg::WP_LOCKED: begin
                if (hwdata[1:0] == rtc_cal_pkg::UNLOCK_FIRST) begin
                  s_d.wp = rtc_cal_pkg::WP_ARMED;
                end
              end
              rtc_cal_pkg::WP_ARMED: begin
                s_d.wp = (hwdata[1:0] == rtc_cal_pkg::UNLOCK_SECOND) ?
                         rtc_cal_pkg::WP_OPEN : rtc_cal_pkg::WP_LOCKED;
              end
              default: s_d.wp = rtc_cal_pkg::WP_LOCKED;
            endcase
          end
        end
        default: ;
      endcase
    end

    s_d.lf_osc_on = s_q.lf_osc_on | s_d.src_sel;

    // --------------------------------------------------------------
    // Flags and interrupt
    // --------------------------------------------------------------
    flag_set = 6'h00;
    flag_set[rtc_cal_pkg::FLAG_QSEC_BIT] = qtick;
    flag_set[rtc_cal_pkg::FLAG_COMP_BIT] = last_sec;
    flag_set[rtc_cal_pkg::FLAG_SEC_BIT]  = sec_tick;
    flag_set[rtc_cal_pkg::FLAG_MIN_BIT]  = sec_wrap;
    flag_set[rtc_cal_pkg::FLAG_HR_BIT]   = min_wrap;
    // A new event outranks a clear in the same cycle
    s_d.flags = ((s_q.flags & ~flag_clr) | flag_set) & 6'h3d;
    s_d.irq = |(s_q.flags & s_q.irq_en);

    // --------------------------------------------------------------
    // Address phase: capture writes, prepare read data
    // --------------------------------------------------------------
    rd_sel = hsel && hready && htrans[1] &&
             (hsize == rtc_cal_pkg::HSIZE_WORD);
    s_d.wr_pend = rd_sel && hwrite;
    s_d.wr_addr = haddr[7:0];
    rd_data = 32'h0000_0000;
    unique case (haddr[7:0])
      rtc_cal_pkg::OFF_CTRL: begin
        rd_data[rtc_cal_pkg::CTRL_ENABLE_BIT] = s_q.enable;
        rd_data[rtc_cal_pkg::CTRL_SRC_BIT]    = s_q.src_sel;
        rd_data[rtc_cal_pkg::CTRL_PRESC_LSB +: 8] = s_q.prescaler;
      end
      rtc_cal_pkg::OFF_IRQ_CONTROL: rd_data[5:0] = s_q.irq_en;
      rtc_cal_pkg::OFF_STATUS: begin
        rd_data[5:0] = s_q.flags;
        rd_data[rtc_cal_pkg::STATUS_BUSY_BIT] = s_q.busy;
      end
      rtc_cal_pkg::OFF_COMP_CONFIG: rd_data[7:0] = {s_q.ccs, s_q.q};
      rtc_cal_pkg::OFF_TICK_COUNT:  rd_data[15:0] = s_q.cnt;
      rtc_cal_pkg::OFF_TICK_LIMIT:  rd_data[15:0] = s_q.limit;
      rtc_cal_pkg::OFF_SECONDS: rd_data[5:0] = s_q.sec;
      rtc_cal_pkg::OFF_MINUTES: rd_data[5:0] = s_q.min;
      rtc_cal_pkg::OFF_HOURS:   rd_data[4:0] = s_q.hr;
      rtc_cal_pkg::OFF_UNLOCK: begin
        rd_data[rtc_cal_pkg::UNLOCK_STATE_LSB +: 2] = s_q.wp;
      end
      default: rd_data = 32'h0000_0000;
    endcase
    s_d.hrdata    = (rd_sel && !hwrite) ? rd_data : 32'h0000_0000;
    s_d.hreadyout = 1'b1;
    s_d.hresp     = 1'b0;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q           <= '0;
      s_q.limit     <= rtc_cal_pkg::LIMIT_RESET;
      s_q.w_limit   <= rtc_cal_pkg::LIMIT_RESET;
      s_q.cnt       <= rtc_cal_pkg::COUNT_RESET;
      s_q.hreadyout <= 1'b1;
      s_q.wp        <= rtc_cal_pkg::WP_OPEN;
    end else begin
      s_q <= s_d;
    end
  end
  assign hrdata         = s_q.hrdata;
  assign hreadyout      = s_q.hreadyout;
  assign hresp          = s_q.hresp;
  assign low_osc_enable = s_q.lf_osc_on;
  assign irq_request    = s_q.irq;

endmodule : rtc_calendar_compensation

`default_nettype wire

// >>> rtc_calendar_compensation_assertions.sv
// Port checker for the calendar counter bus and status outputs
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_compensation_checker (
  input wire logic        hclk,               // Clock
  input wire logic        hresetn,            // Reset, active low
  input wire logic        hsel,               // Select
  input wire logic [31:0] haddr,              // Address
  input wire logic [1:0]  htrans,             // Transfer type
  input wire logic        hwrite,             // Write
  input wire logic [2:0]  hsize,              // Size
  input wire logic [31:0] hwdata,             // Write data
  input wire logic        hready,             // Ready in
  input wire logic [31:0] hrdata,             // Read data
  input wire logic        hreadyout,          // Ready out
  input wire logic        hresp,              // Response
  input wire logic        main_osc_clock,     // Main oscillator
  input wire logic        low_freq_osc_clock, // 32 kHz oscillator
  input wire logic        low_osc_enable,     // Oscillator keep-on
  input wire logic        irq_request         // Interrupt
);
  // ------------------------------------------------------------
  // Data phase tracking
  // ------------------------------------------------------------
  logic       rd_dp_q;
  logic       wr_dp_q;
  logic [7:0] dp_addr_q;
  logic       taken;
  logic       src_wr;
  assign taken = hsel && hready && htrans[1]
                 && (hsize == rtc_cal_pkg::HSIZE_WORD);
  assign src_wr = wr_dp_q && (dp_addr_q == rtc_cal_pkg::OFF_CTRL)
                  && hwdata[rtc_cal_pkg::CTRL_SRC_BIT];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dp_q   <= 1'b0;
      wr_dp_q   <= 1'b0;
      dp_addr_q <= 8'h00;
    end else begin
      rd_dp_q <= taken && !hwrite;
      wr_dp_q <= taken && hwrite;
      if (taken) begin
        dp_addr_q <= haddr[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_ready_always: assert property (hreadyout)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (!hresp)
    else $error("slave answered with an error");
  a_rdata_idle: assert property (!rd_dp_q |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  a_sec_range: assert property (
    rd_dp_q && dp_addr_q == rtc_cal_pkg::OFF_SECONDS |-> hrdata <= 32'h3b)
    else $error("seconds out of range");
  a_hr_range: assert property (
    rd_dp_q && dp_addr_q == rtc_cal_pkg::OFF_HOURS |-> hrdata <= 32'h17)
    else $error("hours out of range");
  a_osc_sticky: assert property (low_osc_enable |=> low_osc_enable)
    else $error("low oscillator switched off");
  a_osc_cause: assert property ($rose(low_osc_enable) |->
    $past(src_wr) || $past(src_wr, 2) || $past(src_wr, 3))
    else $error("low oscillator on without source select");
  a_irq_clear: assert property ($fell(irq_request) |->
    $past(wr_dp_q) || $past(wr_dp_q, 2) || $past(wr_dp_q, 3))
    else $error("interrupt dropped without a write");
endmodule : rtc_calendar_compensation_checker

bind rtc_calendar_compensation rtc_calendar_compensation_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .main_osc_clock(main_osc_clock), .low_freq_osc_clock(low_freq_osc_clock),
  .low_osc_enable(low_osc_enable), .irq_request(irq_request));
`default_nettype wire

// >>> rtc_calendar_compensation_tb_top.sv
// Self-checking testbench of the calendar counter
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_compensation_tb_top;
  logic        hclk, hresetn, hsel, hwrite, mclk, lclk;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic        hreadyout, hresp, low_osc_enable, irq_request;
  int          n_errors, checks, cyc;

  rtc_calendar_compensation u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .main_osc_clock(mclk), .low_freq_osc_clock(lclk),
    .low_osc_enable(low_osc_enable), .irq_request(irq_request));

  // ------------------------------------------------------------
  // Clocks and timeout
  // ------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // Oscillators scaled up so a second lasts tens of cycles from the 32 kHz clock, hundreds from the main
  initial begin
    mclk = 1'b0;
    #1;
    forever #20 mclk = ~mclk;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever #40 lclk = ~lclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task summarize;
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, v);
    chk(nm, e, v);
  endtask : rdc

  task wait_sec(input int n);
    logic [31:0] a;
    bus(1'b0, rtc_cal_pkg::OFF_SECONDS, 32'h0, a);
    repeat (n) begin
      do bus(1'b0, rtc_cal_pkg::OFF_SECONDS, 32'h0, v); while (v === a);
      a = v;
    end
  endtask : wait_sec

  // Disables right after a second boundary so the held count stays low
  task measure(input logic [31:0] c, input logic [31:0] cc, input int n,
               input int e);
    int t;
    wr(rtc_cal_pkg::OFF_CTRL, c & ~32'h1);
    wr(rtc_cal_pkg::OFF_COMP_CONFIG, cc);
    wr(rtc_cal_pkg::OFF_CTRL, c);
    wait_sec(1);
    t = cyc;
    wait_sec(n);
    t = cyc - t;
    wr(rtc_cal_pkg::OFF_CTRL, c & ~32'h1);
    // Polling granularity is a few cycles
    if (t >= e - 4 && t <= e + 4) begin
      t = e;
    end
    chk("second_cycles", e, t);
  endtask : measure

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Main source: 4 ticks of 32 main periods, prescaler divides by one
  task t_main;
    measure(32'h1, 32'h0, 1, 640);
    chk("osc_idle", 32'h0, {31'h0, low_osc_enable});
  endtask : t_main

  task t_reset;
    rdc("tick_limit", rtc_cal_pkg::OFF_TICK_LIMIT, 32'h0);
    rdc("tick_count", rtc_cal_pkg::OFF_TICK_COUNT, 32'h0);
    rdc("unlock_state", rtc_cal_pkg::OFF_UNLOCK, 32'h0);
    rdc("unmapped", 8'h28, 32'h0);
    wr(rtc_cal_pkg::OFF_STATUS, 32'h80);
    rdc("status", rtc_cal_pkg::OFF_STATUS, 32'h0);
    wr(rtc_cal_pkg::OFF_TICK_LIMIT, 32'habcd);
    rdc("limit_rw", rtc_cal_pkg::OFF_TICK_LIMIT, 32'habcd);
    wr(rtc_cal_pkg::OFF_TICK_LIMIT, 32'h3);
  endtask : t_reset

  task t_range;
    logic [7:0] a [3] = '{rtc_cal_pkg::OFF_SECONDS,
                          rtc_cal_pkg::OFF_MINUTES, rtc_cal_pkg::OFF_HOURS};
    logic [7:0] m [3] = '{8'h3b, 8'h3b, 8'h17};
    for (int i = 0; i < 3; i++) begin
      wr(a[i], {24'h0, m[i]});
      rdc("time_max", a[i], {24'h0, m[i]});
      wr(a[i], {24'h0, m[i] + 8'h01});
      rdc("time_over", a[i], {24'h0, m[i]});
      wr(a[i], 32'h43);
      rdc("time_byte", a[i], {24'h0, m[i]});
    end
  endtask : t_range

  task t_protect;
    wr(rtc_cal_pkg::OFF_UNLOCK, 32'h0);
    bus(1'b0, rtc_cal_pkg::OFF_UNLOCK, 32'h0, v);
    chk("locked", 32'h4, v & 32'hc);
    wr(rtc_cal_pkg::OFF_SECONDS, 32'h5);
    rdc("locked_write", rtc_cal_pkg::OFF_SECONDS, 32'h3b);
    wr(rtc_cal_pkg::OFF_CTRL, 32'h1);
    rdc("locked_ctrl", rtc_cal_pkg::OFF_CTRL, 32'h0);
    wr(rtc_cal_pkg::OFF_UNLOCK, 32'h2);
    bus(1'b0, rtc_cal_pkg::OFF_UNLOCK, 32'h0, v);
    chk("armed", 32'h8, v & 32'hc);
    wr(rtc_cal_pkg::OFF_UNLOCK, 32'h1);
    bus(1'b0, rtc_cal_pkg::OFF_UNLOCK, 32'h0, v);
    chk("reopened", 32'h0, v & 32'hc);
    wr(rtc_cal_pkg::OFF_SECONDS, 32'h3a);
    rdc("open_write", rtc_cal_pkg::OFF_SECONDS, 32'h3a);
    wr(rtc_cal_pkg::OFF_SECONDS, 32'h3b);
  endtask : t_protect

  // Full carry from 23:59:59 with flags, interrupt and clearing
  task t_calendar;
    wr(rtc_cal_pkg::OFF_STATUS, 32'h3f);
    wr(rtc_cal_pkg::OFF_IRQ_CONTROL, 32'h8);
    wr(rtc_cal_pkg::OFF_COMP_CONFIG, 32'h0);
    wr(rtc_cal_pkg::OFF_CTRL, 32'h2);
    repeat (50) @(posedge hclk);
    wr(rtc_cal_pkg::OFF_CTRL, 32'h3);
    wait_sec(1);
    wr(rtc_cal_pkg::OFF_CTRL, 32'h2);
    rdc("sec_wrap", rtc_cal_pkg::OFF_SECONDS, 32'h0);
    rdc("min_wrap", rtc_cal_pkg::OFF_MINUTES, 32'h0);
    rdc("hr_wrap", rtc_cal_pkg::OFF_HOURS, 32'h0);
    bus(1'b0, rtc_cal_pkg::OFF_STATUS, 32'h0, v);
    chk("flags_set", 32'h39, v & 32'h3d);
    chk("irq_on", 32'h1, {31'h0, irq_request});
    wr(rtc_cal_pkg::OFF_STATUS, 32'h0);
    bus(1'b0, rtc_cal_pkg::OFF_STATUS, 32'h0, v);
    chk("flags_w0", 32'h39, v & 32'h3d);
    wr(rtc_cal_pkg::OFF_STATUS, 32'h3f);
    bus(1'b0, rtc_cal_pkg::OFF_STATUS, 32'h0, v);
    chk("flags_w1c", 32'h0, v & 32'h3d);
    chk("irq_off", 32'h0, {31'h0, irq_request});
    wr(rtc_cal_pkg::OFF_IRQ_CONTROL, 32'h0);
  endtask : t_calendar

  // Five seconds of limit 3 span 20 ticks plus one per long second
  task t_comp;
    wr(rtc_cal_pkg::OFF_STATUS, 32'h3f);
    measure(32'h3, 32'h00, 5, 200);
    bus(1'b0, rtc_cal_pkg::OFF_STATUS, 32'h0, v);
    chk("comp_flag", 32'h4, v & 32'h4);
    measure(32'h3, 32'h02, 5, 220);
    measure(32'h3, 32'h05, 5, 250);
    measure(32'h3, 32'h07, 5, 250);
    measure(32'h3, 32'h41, 15, 610);
    measure(32'h3, 32'h81, 30, 1210);
    measure(32'h3, 32'hc1, 60, 2410);
    wr(rtc_cal_pkg::OFF_CTRL, 32'h0);
    chk("osc_stays", 32'h1, {31'h0, low_osc_enable});
  endtask : t_comp

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    n_errors = 0;
    checks = 0;
    cyc = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_main();
    t_range();
    t_protect();
    t_calendar();
    t_comp();
    summarize();
  end
endmodule : rtc_calendar_compensation_tb_top
`default_nettype wire
